// File: inc/tmc_pkg.sv
package tmc_pkg;
	// Register byte addresses on the APB bus
	localparam logic [7:0] TMC_ADDR_CTRL = 8'h00;
	localparam logic [7:0] TMC_ADDR_LOW = 8'h04;
	localparam logic [7:0] TMC_ADDR_HIGH = 8'h08;
	localparam logic [7:0] TMC_ADDR_IRQ = 8'h0C;
	// Control field positions
	localparam int TMC_BIT_ON = 7;
	localparam int TMC_BIT_W8 = 6;
	localparam int TMC_BIT_SRC = 5;
	localparam int TMC_BIT_EDGE = 4;
	localparam int TMC_BIT_BYP = 3;
	localparam int TMC_PS_MSB = 2;
	// Interrupt control field positions
	localparam int TMC_BIT_IE = 5;
	localparam int TMC_BIT_IF = 2;
	// Reset values and byte constants
	localparam logic [7:0] TMC_CTRL_RST = 8'hFF;
	localparam logic [7:0] TMC_HIGH_RST = 8'h00;
	localparam logic [7:0] TMC_ZERO8 = 8'h00;
	localparam logic [7:0] TMC_ONES8 = 8'hFF;
	// Write to the low byte stalls counting for this many cycles
	localparam logic [1:0] TMC_INHIBIT_CYC = 2'h2;
	typedef struct packed {
		logic on;
		logic w8;
		logic src;
		logic edge_fall;
		logic bypass;
		logic [2:0] ratio;
	} tmc_ctrl_t;
	typedef enum logic [1:0] {
		TMC_RUN = 2'b00,
		TMC_INH1 = 2'b01,
		TMC_INH2 = 2'b11
	} tmc_state_t;
endpackage

// File: core/tmc_timer.sv
// Chosen here: the APB slave port and the address map.
`timescale 1ns/1ns
// Overview of operation
// RQ1 - Control bit 7 enables counting
// RQ2 - Bit 6 selects 8-bit or 16-bit
// RQ3 - Bit 5 selects pin or cycle source
// RQ4 - Bit 4 selects falling or rising edge
// RQ5 - Bit 3 bypasses the prescaler
// RQ6 - Ratio field divides by two to 256
// RQ7 - All resets set control to FFh
// RQ8 - Timer mode counts every cycle
// RQ9 - Low byte write stalls two cycles
// RQ10 - Pin synchronized before use
// RQ11 - Prescaler hidden from software
// RQ12 - Count write clears prescaler count (code clears it only while bit 3 bypass is clear)
// RQ13 - Assignment changes allowed while running
// RQ14 - Wrap to zero sets overflow flag
// RQ15 - Enable masks request, not flag
// RQ16 - Software clears flag before re-enabling
// RQ17 - Counting halts during sleep
// RQ18 - Low read latches upper byte
// RQ19 - High buffer then low write
// RQ20 - Prescaled: one step per N events
module tmc_timer
	import tmc_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_sys_rst,
	input wire logic i_sleep,
	input wire logic i_ext_count_pin,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic o_irq
);
	tmc_ctrl_t ctrl_reg;
	logic [7:0] low_reg;
	logic [7:0] upper_reg;
	logic [7:0] high_buf_reg;
	logic ie_reg;
	logic flag_reg;
	logic [7:0] pre_reg;
	logic [7:0] pre_next;
	logic pin_s1_reg;
	logic pin_s2_reg;
	logic pin_prev_reg;
	tmc_state_t state_reg;
	logic access;
	logic wr_ctrl;
	logic wr_low;
	logic wr_high;
	logic wr_irq;
	logic rd_low;
	logic rd_low_setup;
	logic [7:0] upper_snap_reg;
	logic mapped;
	logic src_event;
	logic step;
	logic wrap;
	logic [15:0] cnt_next;

	function automatic logic [7:0] tmc_ratio_mask(input logic [2:0] r);
		// Terminal value of the prescaler for divide by 2^(r+1)
		tmc_ratio_mask = 8'((16'h0001 << ({1'b0, r} + 4'h1)) - 16'h0001);
	endfunction

	assign access = psel && penable;
	assign mapped = (paddr == TMC_ADDR_CTRL) || (paddr == TMC_ADDR_LOW)
		|| (paddr == TMC_ADDR_HIGH) || (paddr == TMC_ADDR_IRQ);
	assign wr_ctrl = access && pwrite && (paddr == TMC_ADDR_CTRL);
	assign wr_low = access && pwrite && (paddr == TMC_ADDR_LOW);
	assign wr_high = access && pwrite && (paddr == TMC_ADDR_HIGH);
	assign wr_irq = access && pwrite && (paddr == TMC_ADDR_IRQ);
	assign rd_low = access && !pwrite && (paddr == TMC_ADDR_LOW);
	assign rd_low_setup = psel && !penable && !pwrite && (paddr == TMC_ADDR_LOW);

	// Two-flop synchronizer, then edge detect on the second stage
	always_ff @(posedge i_clock)
	begin
		if (i_sys_rst)
		begin
			pin_s1_reg <= 1'b0;
			pin_s2_reg <= 1'b0;
			pin_prev_reg <= 1'b0;
		end
		else
		begin
			pin_s1_reg <= i_ext_count_pin; // RQ10
			pin_s2_reg <= pin_s1_reg;
			pin_prev_reg <= pin_s2_reg;
		end
	end

	always_comb
	begin
		if (ctrl_reg.src) // RQ3
			src_event = ctrl_reg.edge_fall ? (pin_prev_reg && !pin_s2_reg) // RQ4
				: (!pin_prev_reg && pin_s2_reg);
		else
			src_event = 1'b1; // RQ8
	end

	// Prescaler: a plain counter with no bus path
	always_comb
	begin
		pre_next = pre_reg;
		step = 1'b0;
		if (ctrl_reg.on && !i_sleep && state_reg == TMC_RUN && src_event) // RQ1 RQ17 RQ9
		begin
			if (ctrl_reg.bypass) // RQ5 RQ13
				step = 1'b1;
			else if ((pre_reg & tmc_ratio_mask(ctrl_reg.ratio)) == tmc_ratio_mask(ctrl_reg.ratio)) // RQ6 RQ20
			begin
				step = 1'b1;
				pre_next = TMC_ZERO8;
			end
			else
				pre_next = 8'(pre_reg + 8'h01);
		end
	end

	always_ff @(posedge i_clock)
	begin
		if (i_sys_rst)
			pre_reg <= TMC_ZERO8;
		else if (wr_low && !ctrl_reg.bypass)
			pre_reg <= TMC_ZERO8; // RQ12 RQ11
		else
			pre_reg <= pre_next;
	end

	assign cnt_next = 16'({upper_reg, low_reg} + 16'h0001);
	assign wrap = step && (ctrl_reg.w8 ? (low_reg == TMC_ONES8) // RQ2 RQ14
		: ({upper_reg, low_reg} == {TMC_ONES8, TMC_ONES8}));

	always_ff @(posedge i_clock)
	begin
		if (i_sys_rst)
		begin
			low_reg <= TMC_ZERO8;
			upper_reg <= TMC_ZERO8;
		end
		else if (wr_low)
		begin
			low_reg <= pwdata[7:0];
			upper_reg <= high_buf_reg; // RQ19
		end
		else if (step)
		begin
			low_reg <= cnt_next[7:0];
			if (!ctrl_reg.w8) // RQ2
				upper_reg <= cnt_next[15:8];
		end
	end

	// Inhibit sequence after a low byte write
	always_ff @(posedge i_clock)
	begin
		if (i_sys_rst)
			state_reg <= TMC_RUN;
		else if (wr_low)
			state_reg <= TMC_INH1; // RQ9
		else
		begin
			unique case (state_reg)
				TMC_RUN: state_reg <= TMC_RUN;
				TMC_INH1: state_reg <= TMC_INH2;
				TMC_INH2: state_reg <= TMC_RUN;
				default: state_reg <= TMC_RUN;
			endcase
		end
	end

	always_ff @(posedge i_clock)
	begin
		if (i_sys_rst)
			ctrl_reg <= TMC_CTRL_RST; // RQ7
		else if (wr_ctrl)
			ctrl_reg <= pwdata[7:0]; // RQ13
	end

	always_ff @(posedge i_clock)
	begin
		if (i_sys_rst)
			high_buf_reg <= TMC_HIGH_RST;
		else if (wr_high)
			high_buf_reg <= pwdata[7:0];
		else if (rd_low)
			high_buf_reg <= upper_snap_reg; // RQ18
	end

	// Upper byte is taken in the cycle that also fixes the low byte read data
	always_ff @(posedge i_clock)
	begin
		if (i_sys_rst)
			upper_snap_reg <= TMC_ZERO8;
		else if (rd_low_setup)
			upper_snap_reg <= upper_reg; // RQ18
	end

	// Flag: hardware set wins over a software clear in the same cycle
	always_ff @(posedge i_clock)
	begin
		if (i_sys_rst)
		begin
			ie_reg <= 1'b0;
			flag_reg <= 1'b0;
		end
		else
		begin
			if (wr_irq)
				ie_reg <= pwdata[TMC_BIT_IE];
			if (wrap)
				flag_reg <= 1'b1; // RQ14 RQ15
			else if (wr_irq)
				flag_reg <= pwdata[TMC_BIT_IF]; // RQ16
		end
	end

	always_ff @(posedge i_clock)
	begin
		if (i_sys_rst)
			o_irq <= 1'b0;
		else
			o_irq <= (flag_reg || wrap) && ie_reg; // RQ15
	end

	// APB: no wait state, answer in the access cycle's second edge
	always_ff @(posedge i_clock)
	begin
		if (i_sys_rst)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end
		else
		begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !mapped;
			prdata <= '0;
			if (psel && !penable && !pwrite)
			begin
				unique case (paddr)
					TMC_ADDR_CTRL: prdata[7:0] <= ctrl_reg;
					TMC_ADDR_LOW: prdata[7:0] <= low_reg;
					TMC_ADDR_HIGH: prdata[7:0] <= high_buf_reg;
					TMC_ADDR_IRQ:
					begin
						prdata[TMC_BIT_IE] <= ie_reg;
						prdata[TMC_BIT_IF] <= flag_reg;
					end
					default: prdata <= '0;
				endcase
			end
		end
	end

	wire access_done = access && pready;

	sequence low_write_s;
		wr_low && access_done;
	endsequence

	sequence inhibit_s;
		state_reg == TMC_INH1 ##1 state_reg == TMC_INH2;
	endsequence

	stall_two_a: assert property (@(posedge i_clock) disable iff (i_sys_rst) // RQ9
		low_write_s |=> !step [*2])
		else $error("count advanced during the inhibit window");
	ctrl_reset_a: assert property (@(posedge i_clock) $fell(i_sys_rst) |-> ctrl_reg == TMC_CTRL_RST) // RQ7
		else $error("control not all ones after reset");
	stop_hold_a: assert property (@(posedge i_clock) disable iff (i_sys_rst) // RQ1
		!ctrl_reg.on && !wr_low |=> $stable(low_reg))
		else $error("count moved while disabled");
	sleep_hold_a: assert property (@(posedge i_clock) disable iff (i_sys_rst) // RQ17
		i_sleep |-> !step)
		else $error("count advanced in sleep");
	wrap_flag_a: assert property (@(posedge i_clock) disable iff (i_sys_rst) // RQ14
		wrap |=> flag_reg)
		else $error("overflow did not set flag");
	mask_irq_a: assert property (@(posedge i_clock) disable iff (i_sys_rst) // RQ15
		!ie_reg |=> !o_irq)
		else $error("masked request reached output");
	byte_hold_a: assert property (@(posedge i_clock) disable iff (i_sys_rst) // RQ2
		ctrl_reg.w8 && !wr_low |=> $stable(upper_reg))
		else $error("upper byte moved in 8-bit mode");
	read_latch_a: assert property (@(posedge i_clock) disable iff (i_sys_rst) // RQ18
		rd_low && !wr_high |=> high_buf_reg == $past(upper_reg, 2))
		else $error("low read did not latch upper byte");
	load_pair_a: assert property (@(posedge i_clock) disable iff (i_sys_rst) // RQ19
		wr_low |=> upper_reg == $past(high_buf_reg) && low_reg == $past(pwdata[7:0]))
		else $error("16-bit load wrong");
	pre_clear_a: assert property (@(posedge i_clock) disable iff (i_sys_rst) // RQ12
		wr_low && !ctrl_reg.bypass |=> pre_reg == TMC_ZERO8)
		else $error("prescaler not cleared on count write");
	timer_step_a: assert property (@(posedge i_clock) disable iff (i_sys_rst) // RQ8
		ctrl_reg.on && ctrl_reg.bypass && !ctrl_reg.src && !i_sleep && state_reg == TMC_RUN |-> step)
		else $error("timer mode missed a cycle");

	// Inhibit order, source, prescaler, wrap, flag, request, high buffer and APB handshake checks
	inh_order_a: assert property (@(posedge i_clock) disable iff (i_sys_rst) // RQ9
		low_write_s |=> inhibit_s)
		else $error("inhibit states out of order");
	edge_rise_a: assert property (@(posedge i_clock) disable iff (i_sys_rst) // RQ4
		ctrl_reg.src && !ctrl_reg.edge_fall && $rose(pin_s2_reg) |-> src_event)
		else $error("rising pin edge not counted");
	edge_fall_a: assert property (@(posedge i_clock) disable iff (i_sys_rst) // RQ4
		ctrl_reg.src && ctrl_reg.edge_fall && $fell(pin_s2_reg) |-> src_event)
		else $error("falling pin edge not counted");
	src_gate_a: assert property (@(posedge i_clock) disable iff (i_sys_rst) // RQ3
		ctrl_reg.src && !$changed(pin_s2_reg) |-> !src_event)
		else $error("pin source event without an edge");
	pre_wrap_a: assert property (@(posedge i_clock) disable iff (i_sys_rst) // RQ20
		!ctrl_reg.bypass && step |=> pre_reg == TMC_ZERO8)
		else $error("prescaler not restarted after a step");
	bypass_keep_a: assert property (@(posedge i_clock) disable iff (i_sys_rst) // RQ5
		ctrl_reg.bypass |=> $stable(pre_reg))
		else $error("prescaler moved while bypassed");
	sleep_pre_a: assert property (@(posedge i_clock) disable iff (i_sys_rst) // RQ17
		i_sleep && !wr_low |=> $stable(pre_reg))
		else $error("prescaler moved in sleep");
	wrap_zero_a: assert property (@(posedge i_clock) disable iff (i_sys_rst) // RQ14
		wrap && !wr_low |=> low_reg == TMC_ZERO8)
		else $error("overflow did not wrap to zero");
	flag_keep_a: assert property (@(posedge i_clock) disable iff (i_sys_rst) // RQ16
		flag_reg && !wr_irq |=> flag_reg)
		else $error("flag cleared without software");
	irq_follow_a: assert property (@(posedge i_clock) disable iff (i_sys_rst) // RQ15
		ie_reg && flag_reg |=> o_irq)
		else $error("enabled flag did not raise request");
	high_write_a: assert property (@(posedge i_clock) disable iff (i_sys_rst) // RQ19
		wr_high |=> high_buf_reg == $past(pwdata[7:0]))
		else $error("high buffer write lost");
	ready_pulse_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
		psel && !penable |=> pready)
		else $error("no ready in access cycle");
	err_pair_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
		pslverr |-> pready)
		else $error("error without ready");
endmodule // tmc_timer

// File: verification/tmc_pin_model.sv
`timescale 1ns/1ns
module tmc_pin_model
(
	input wire logic i_clock,
	output logic o_pin
);
	initial o_pin = 1'b0;
	// Each level is held four cycles so that the synchronizer sees every edge
	task automatic toggle(input int n);
		repeat (n)
		begin
			@(posedge i_clock);
			o_pin <= !o_pin;
			repeat (3) @(posedge i_clock);
		end
	endtask
endmodule // tmc_pin_model

// File: verification/tmc_timer_tb.sv
`timescale 1ns/1ns
module tmc_timer_tb
	import tmc_pkg::*;
;
	logic i_clock, i_sys_rst, i_sleep, psel, penable, pwrite, pready, pslverr, o_irq, ext_pin, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd, c0, c1;
	int miscompares, comparisons;
	tmc_timer u_tmc_timer (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_sleep(i_sleep),
		.i_ext_count_pin(ext_pin), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .o_irq(o_irq));
	tmc_pin_model u_tmc_pin_model (.i_clock(i_clock), .o_pin(ext_pin));
	initial
	begin
		i_clock = 1'b0;
		forever #4 i_clock = ~i_clock;
	end
	task automatic give_verdict();
		if (miscompares == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e)
		begin
			$display("unexpected %s: expected %h seen %h", n, e, g);
			miscompares++;
		end
	endtask
	// Request is held until pready is seen; release is left to the next call
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge i_clock);
		penable <= 1'b1;
		do
		begin
			@(posedge i_clock);
			k++;
		end
		while (pready !== 1'b1 && k < 16);
		rd = prdata;
		err = pslverr;
		if (pready !== 1'b1)
		begin
			miscompares++;
			give_verdict();
		end
	endtask
	task automatic idle(input int n);
		psel <= 1'b0;
		penable <= 1'b0;
		repeat (n) @(posedge i_clock);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		xfer(1'b1, a, {24'h0, d});
	endtask
	task automatic rdc(input logic [7:0] a, input string n, input logic [7:0] e);
		xfer(1'b0, a, 32'h0);
		chk(n, {24'h0, e}, rd);
	endtask
	// Counts gathered over one enable window of g idle cycles
	task automatic run(input logic [7:0] c, input int g, output logic [31:0] n);
		wr(TMC_ADDR_CTRL, c & 8'h7F);
		wr(TMC_ADDR_LOW, 8'h00);
		idle(4);
		wr(TMC_ADDR_CTRL, c);
		idle(g);
		wr(TMC_ADDR_CTRL, c & 8'h7F);
		xfer(1'b0, TMC_ADDR_LOW, 32'h0);
		n = rd;
	endtask
	initial
	begin
		i_sys_rst = 1'b1;
		i_sleep = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		miscompares = 0;
		comparisons = 0;
		repeat (10) @(posedge i_clock);
		i_sys_rst <= 1'b0;
		rdc(TMC_ADDR_CTRL, "control", TMC_CTRL_RST);
		rdc(TMC_ADDR_HIGH, "high", TMC_HIGH_RST);
		xfer(1'b0, 8'h10, 32'h0);
		chk("unmapped data", 32'h0, rd);
		chk("unmapped error", 32'h1, {31'h0, err});
		wr(TMC_ADDR_CTRL, 8'h08);
		wr(TMC_ADDR_HIGH, 8'h12);
		wr(TMC_ADDR_LOW, 8'h34);
		rdc(TMC_ADDR_LOW, "low", 8'h34);
		rdc(TMC_ADDR_HIGH, "high latch", 8'h12);
		wr(TMC_ADDR_HIGH, 8'hFF);
		wr(TMC_ADDR_LOW, 8'hFF);
		wr(TMC_ADDR_IRQ, 8'h00);
		wr(TMC_ADDR_CTRL, 8'h88);
		idle(4);
		wr(TMC_ADDR_CTRL, 8'h08);
		rdc(TMC_ADDR_IRQ, "wide flag", 8'h04);
		xfer(1'b0, TMC_ADDR_LOW, 32'h0);
		rdc(TMC_ADDR_HIGH, "wide upper", 8'h00);
		wr(TMC_ADDR_IRQ, 8'h00);
		wr(TMC_ADDR_LOW, 8'hFE);
		wr(TMC_ADDR_CTRL, 8'hC8);
		idle(8);
		rdc(TMC_ADDR_IRQ, "byte flag", 8'h04);
		chk("irq masked", 32'h0, {31'h0, o_irq});
		wr(TMC_ADDR_IRQ, 8'h24);
		idle(2);
		chk("irq raised", 32'h1, {31'h0, o_irq});
		wr(TMC_ADDR_IRQ, 8'h20);
		idle(2);
		chk("irq cleared", 32'h0, {31'h0, o_irq});
		wr(TMC_ADDR_LOW, 8'hF0);
		xfer(1'b0, TMC_ADDR_LOW, 32'h0);
		rdc(TMC_ADDR_LOW, "held", 8'hF0);
		rdc(TMC_ADDR_LOW, "resumed", 8'hF2);
		run(8'hC8, 1, c0);
		run(8'hC8, 11, c1);
		chk("cycle rate", 32'hA, c1 - c0);
		for (int r = 0; r < 8; r++)
		begin
			run(8'hC0 | 8'(r), 1, c0);
			run(8'hC0 | 8'(r), 1 + (8 << r), c1);
			chk("prescaled rate", 32'h4, c1 - c0);
		end
		i_sleep <= 1'b1;
		run(8'hC8, 20, c0);
		chk("sleep", 32'h0, c0);
		i_sleep <= 1'b0;
		wr(TMC_ADDR_CTRL, 8'hE8);
		wr(TMC_ADDR_LOW, 8'h00);
		idle(4);
		u_tmc_pin_model.toggle(5);
		idle(6);
		rdc(TMC_ADDR_LOW, "rising edges", 8'h03);
		wr(TMC_ADDR_CTRL, 8'hF8);
		wr(TMC_ADDR_LOW, 8'h00);
		idle(4);
		u_tmc_pin_model.toggle(5);
		idle(6);
		rdc(TMC_ADDR_LOW, "falling edges", 8'h03);
		wr(TMC_ADDR_CTRL, 8'h00);
		idle(1);
		i_sys_rst <= 1'b1;
		repeat (2) @(posedge i_clock);
		i_sys_rst <= 1'b0;
		rdc(TMC_ADDR_CTRL, "control after reset", TMC_CTRL_RST);
		rdc(TMC_ADDR_IRQ, "irq after reset", 8'h00);
		give_verdict();
	end
endmodule // tmc_timer_tb
